// [logic/fcp_pkg.sv]
/*
 * Shared constants and types of the floating-point compare predicate unit:
 * register offsets, field positions, reset values, format and state codes.
 * Assumes a 32-bit APB register bus and IEEE 754-2008 single and double operands.
 */
package fcp_pkg;

    // Register byte offsets
    localparam logic [7:0] FCP_CTRL_OFF = 8'h00;
    localparam logic [7:0] FCP_CMD_OFF = 8'h04;
    localparam logic [7:0] FCP_OPA_LO_OFF = 8'h08;
    localparam logic [7:0] FCP_OPA_HI_OFF = 8'h0c;
    localparam logic [7:0] FCP_OPB_LO_OFF = 8'h10;
    localparam logic [7:0] FCP_OPB_HI_OFF = 8'h14;
    localparam logic [7:0] FCP_RES_LO_OFF = 8'h18;
    localparam logic [7:0] FCP_RES_HI_OFF = 8'h1c;
    localparam logic [7:0] FCP_STATUS_OFF = 8'h20;
    localparam logic [7:0] FCP_MASK_OFF = 8'h24;
    localparam logic [7:0] FCP_REL_OFF = 8'h28;

    // Control register fields
    localparam int FCP_CTRL_COND_LSB = 0;
    localparam int FCP_CTRL_FMT_LSB = 8;
    localparam int FCP_CTRL_USABLE_BIT = 16;
    localparam logic [31:0] FCP_CTRL_RST = 32'h0000_0000;

    // Command register: writing one to this bit issues a compare
    localparam int FCP_CMD_GO_BIT = 0;

    // Status and mask layout
    localparam int FCP_ST_DONE = 0;
    localparam int FCP_ST_INVALID = 1;
    localparam int FCP_ST_UNIMPL = 2;
    localparam int FCP_ST_COP_UNUSABLE = 3;
    localparam int FCP_ST_RESERVED = 4;
    localparam int FCP_ST_W = 5;
    localparam logic [4:0] FCP_ST_RST = 5'h00;

    // Operand format codes
    localparam logic [1:0] FCP_FMT_SINGLE = 2'h0;
    localparam logic [1:0] FCP_FMT_DOUBLE = 2'h1;

    // Negated-predicate low nibbles that exist; the others are reserved
    localparam logic [15:0] FCP_NEG_IMPL = 16'h0e0e;

    // Condition field bit meanings
    localparam int FCP_C_UN = 0;
    localparam int FCP_C_EQ = 1;
    localparam int FCP_C_LT = 2;
    localparam int FCP_C_SIG = 3;
    localparam int FCP_C_NEG = 4;

    typedef enum logic [1:0] {
        FCP_IDLE = 2'b01,
        FCP_EVAL = 2'b10
    } fcp_state_t;

    // Relations between the two operands
    typedef struct packed {
        logic less;
        logic equal;
        logic unordered;
        logic any_snan;
        logic any_qnan;
        logic any_subnormal;
    } fcp_rel_t;

endpackage

// [logic/fcp_relate.sv]
/*
 * Combinational relation finder: NaN classes, less, equal, unordered
 * for two operands in single or double format.
 * Assumes single operands sit in the low 32 bits of each 64-bit input.
 */
`timescale 1ns/1ps
module fcp_relate (
    // Operands
    input wire logic [63:0] op_a,
    input wire logic [63:0] op_b,
    input wire logic is_double,
    // Relations
    output fcp_pkg::fcp_rel_t rel
);
    import fcp_pkg::*;

    logic [62:0] mag_a, mag_b;
    logic sign_a, sign_b;
    logic nan_a, nan_b, quiet_a, quiet_b, sub_a, sub_b, both_zero, mag_lt, mag_eq;

    always_comb begin
        if (is_double) begin
            sign_a = op_a[63];
            sign_b = op_b[63];
            mag_a = op_a[62:0];
            mag_b = op_b[62:0];
            nan_a = (&op_a[62:52]) && (|op_a[51:0]);
            nan_b = (&op_b[62:52]) && (|op_b[51:0]);
            quiet_a = op_a[51];
            quiet_b = op_b[51];
            sub_a = (op_a[62:52] == 11'h000) && (|op_a[51:0]);
            sub_b = (op_b[62:52] == 11'h000) && (|op_b[51:0]);
        end else begin
            sign_a = op_a[31];
            sign_b = op_b[31];
            mag_a = {32'h0000_0000, op_a[30:0]};
            mag_b = {32'h0000_0000, op_b[30:0]};
            nan_a = (&op_a[30:23]) && (|op_a[22:0]);
            nan_b = (&op_b[30:23]) && (|op_b[22:0]);
            quiet_a = op_a[22];
            quiet_b = op_b[22];
            sub_a = (op_a[30:23] == 8'h00) && (|op_a[22:0]);
            sub_b = (op_b[30:23] == 8'h00) && (|op_b[22:0]);
        end
    end

    assign both_zero = (mag_a == 63'h0) && (mag_b == 63'h0);
    assign mag_lt = mag_a < mag_b;
    assign mag_eq = mag_a == mag_b;

    always_comb begin
        rel.any_snan = (nan_a && !quiet_a) || (nan_b && !quiet_b);
        rel.any_qnan = (nan_a && quiet_a) || (nan_b && quiet_b);
        rel.any_subnormal = sub_a || sub_b;
        if (nan_a || nan_b) begin
            // Any NaN: unordered only
            rel.less = 1'b0;
            rel.equal = 1'b0;
            rel.unordered = 1'b1;
        end else begin
            // Sign-magnitude order; zeros of either sign are equal
            rel.unordered = 1'b0;
            rel.equal = both_zero || (sign_a == sign_b && mag_eq);
            if (both_zero) begin
                rel.less = 1'b0;
            end else if (sign_a != sign_b) begin
                rel.less = sign_a;
            end else if (sign_a) begin
                rel.less = !mag_lt && !mag_eq;
            end else begin
                rel.less = mag_lt;
            end
        end
    end

endmodule // fcp_relate

// [logic/fcp_compare_unit.sv]
/*
 * Floating-point compare-to-register unit with an APB register file.
 * Software loads two operands, the condition code and format, then issues
 * the compare; a mask of format width lands in the result registers.
 * Register map, byte offsets:
 *   0x00 control: condition code, operand format, coprocessor usable
 *   0x04 issue on write of bit 0; reads back busy while evaluating
 *   0x08 to 0x14 operand words, low then high, first operand first
 *   0x18 and 0x1c result words, read only
 *   0x20 sticky status, write one to clear: done, invalid, unimplemented,
 *        coprocessor unusable, reserved instruction
 *   0x24 interrupt mask of the same layout
 *   0x28 relations of the last committed compare, read only
 * Format codes: 0 single (low word only), 1 double; 2 and 3 are reserved.
 * Condition bit 4 negates the predicate, bit 3 makes quiet NaNs signal.
 * A trapped compare sets its status bits and leaves result and relations alone.
 * Assumes an APB3 master on mclk and no other clock.
 */
// The placing of the registers and the APB interface to the registers were left to the implementer.
// Functional notes
// - Any NaN operand forces less and equal false, unordered true.
// - Invalid operation on signalling NaN, or quiet NaN with condition bit 3.
// - Without NaNs, less and equal come from numeric order; unordered cleared.
// - Predicate is gated OR of relations by bits 2..0, XOR bit 4.
// - Predicate outcome written to destination, extended to format width.
// - Quiet codes 4..7 give ordered/unordered less and less-or-equal, never signalling.
// - Codes 8..15 repeat codes 0..7 as signalling forms.
// - Unimplemented condition encodings are reserved, no compare behaviour.
// - Compare can raise coprocessor-unusable and reserved-instruction exceptions.
// - Only unimplemented-operation and invalid-operation floating exceptions exist.
`timescale 1ns/1ps
module fcp_compare_unit #(
    parameter bit SUBNORMAL_SUPPORT = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt and result strobe
    output logic irq,
    output logic result_valid
);
    import fcp_pkg::*;

    logic [31:0] ctrl_reg;
    logic [63:0] opa_reg, opb_reg, res_reg;
    logic [FCP_ST_W-1:0] status_reg, status_next, mask_reg, events;
    logic [3:0] rel_reg;
    fcp_state_t state_reg;
    logic [31:0] rdata_next;
    logic wr_access, rd_setup, addr_ok, go;
    fcp_rel_t rel;
    logic [4:0] cond;
    logic [1:0] fmt;
    logic usable, is_double, fmt_ok, cond_ok, predicate, invalid, unimpl;
    logic wr_ctrl, wr_status, wr_mask, busy, issue_ok, commit;
    logic [2:0] rel_vec, gated;

    assign cond = ctrl_reg[FCP_CTRL_COND_LSB +: 5];
    assign fmt = ctrl_reg[FCP_CTRL_FMT_LSB +: 2];
    assign usable = ctrl_reg[FCP_CTRL_USABLE_BIT];
    assign is_double = fmt == FCP_FMT_DOUBLE;

    // APB decode
    // Control and issue sit below the operand range; the rest is one aligned window
    always_comb begin
        if (paddr == FCP_CTRL_OFF || paddr == FCP_CMD_OFF) begin
            addr_ok = 1'b1;
        end else if (paddr >= FCP_OPA_LO_OFF && paddr <= FCP_REL_OFF && paddr[1:0] == 2'h0) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Zero wait states; read data is captured during the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign wr_access = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign go = wr_access && paddr == FCP_CMD_OFF && pwdata[FCP_CMD_GO_BIT];

    // Register write strobes, decoded once
    assign wr_ctrl = wr_access && paddr == FCP_CTRL_OFF;
    assign wr_status = wr_access && paddr == FCP_STATUS_OFF;
    assign wr_mask = wr_access && paddr == FCP_MASK_OFF;
    assign busy = state_reg == FCP_EVAL;

    // An issue while the previous compare still evaluates is dropped
    assign issue_ok = go && !busy;

    // Relations come straight from the operand registers, no extra pipeline stage
    fcp_relate u_relate (
        .op_a(opa_reg),
        .op_b(opb_reg),
        .is_double(is_double),
        .rel(rel)
    );

    // Format and condition legality
    always_comb begin
        fmt_ok = fmt == FCP_FMT_SINGLE || fmt == FCP_FMT_DOUBLE;
        if (cond[FCP_C_NEG]) begin
            cond_ok = FCP_NEG_IMPL[cond[3:0]];
        end else begin
            cond_ok = 1'b1;
        end
    end

    // Relations in condition-bit order so that bit i of the code gates relation i
    assign rel_vec = {rel.less, rel.equal, rel.unordered};

    for (genvar i = 0; i < 3; i++) begin : g_gate
        assign gated[i] = cond[i] && rel_vec[i];
    end

    // Predicate: one formula covers quiet codes 0..7 and signalling 8..15
    assign predicate = cond[FCP_C_NEG] ^ (|gated);

    // Signalling NaN always traps; quiet NaN only with bit 3
    assign invalid = rel.any_snan || (cond[FCP_C_SIG] && rel.any_qnan);

    // Subnormal operands are handed to software when unsupported
    assign unimpl = !SUBNORMAL_SUPPORT && rel.any_subnormal;

    // Only a compare that traps on nothing may write the destination
    assign commit = busy && usable && fmt_ok && cond_ok && !unimpl && !invalid;

    // Exception priority: unusable, reserved, then the floating exceptions
    // Done is set on a trap too, so software always sees the compare finish
    always_comb begin
        events = '0;
        if (state_reg == FCP_EVAL) begin
            events[FCP_ST_DONE] = 1'b1;
            if (!usable) begin
                events[FCP_ST_COP_UNUSABLE] = 1'b1;
            end else if (!fmt_ok || !cond_ok) begin
                events[FCP_ST_RESERVED] = 1'b1;
            end else if (unimpl) begin
                events[FCP_ST_UNIMPL] = 1'b1;
            end else if (invalid) begin
                events[FCP_ST_INVALID] = 1'b1;
            end
        end
    end

    // Control register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_reg <= FCP_CTRL_RST;
        end else if (wr_ctrl) begin
            // Undefined bits are dropped so that they always read back zero
            ctrl_reg <= pwdata & 32'h0001_031f;
        end
    end

    // Operand registers
    // Operands are read in the evaluation cycle, so load both before the issue
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            opa_reg <= 64'h0;
            opb_reg <= 64'h0;
        end else if (wr_access) begin
            if (paddr == FCP_OPA_LO_OFF) begin
                opa_reg[31:0] <= pwdata;
            end else if (paddr == FCP_OPA_HI_OFF) begin
                opa_reg[63:32] <= pwdata;
            end else if (paddr == FCP_OPB_LO_OFF) begin
                opb_reg[31:0] <= pwdata;
            end else if (paddr == FCP_OPB_HI_OFF) begin
                opb_reg[63:32] <= pwdata;
            end
        end
    end

    // Sequencer: one evaluation cycle after the issue write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= FCP_IDLE;
        end else begin
            case (state_reg)
                FCP_IDLE: begin
                    if (issue_ok) begin
                        state_reg <= FCP_EVAL;
                    end
                end
                FCP_EVAL: begin
                    state_reg <= FCP_IDLE;
                end
                default: begin
                    // Recover from an illegal code rather than lock up
                    state_reg <= FCP_IDLE;
                end
            endcase
        end
    end

    // Destination write; a trapped compare leaves the old value in place
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res_reg <= 64'h0;
            rel_reg <= 4'h0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            if (commit) begin
                if (is_double) begin
                    res_reg <= {64{predicate}};
                end else begin
                    res_reg <= {32'h0000_0000, {32{predicate}}};
                end
                rel_reg <= {predicate, rel.unordered, rel.equal, rel.less};
                result_valid <= 1'b1;
            end
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~pwdata[FCP_ST_W-1:0];
        end
        status_next = status_next | events;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_reg <= FCP_ST_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mask_reg <= FCP_ST_RST;
        end else if (wr_mask) begin
            mask_reg <= pwdata[FCP_ST_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            // Built from the next status, so irq follows an event or a clear by one cycle;
            // a mask change reaches irq one cycle later still
            irq <= |(status_next & mask_reg);
        end
    end

    // Read mux
    // Unmapped addresses read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (paddr == FCP_CTRL_OFF) begin
            rdata_next = ctrl_reg;
        end else if (paddr == FCP_CMD_OFF) begin
            rdata_next = {31'h0, busy};
        end else if (paddr == FCP_OPA_LO_OFF) begin
            rdata_next = opa_reg[31:0];
        end else if (paddr == FCP_OPA_HI_OFF) begin
            rdata_next = opa_reg[63:32];
        end else if (paddr == FCP_OPB_LO_OFF) begin
            rdata_next = opb_reg[31:0];
        end else if (paddr == FCP_OPB_HI_OFF) begin
            rdata_next = opb_reg[63:32];
        end else if (paddr == FCP_RES_LO_OFF) begin
            rdata_next = res_reg[31:0];
        end else if (paddr == FCP_RES_HI_OFF) begin
            rdata_next = res_reg[63:32];
        end else if (paddr == FCP_STATUS_OFF) begin
            rdata_next = {27'h0, status_reg};
        end else if (paddr == FCP_MASK_OFF) begin
            rdata_next = {27'h0, mask_reg};
        end else if (paddr == FCP_REL_OFF) begin
            rdata_next = {28'h0, rel_reg};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rdata_next;
        end
    end

endmodule // fcp_compare_unit

// [verification/fcp_compare_checker.sv]
/* Port-level assertions of the compare unit.
 * Assumes it is bound onto fcp_compare_unit, single clock mclk. */
`timescale 1ns/1ps
module fcp_compare_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events
    input wire logic irq,
    input wire logic result_valid
);
    import fcp_pkg::*;
    logic acc;
    logic rd;
    logic issue;
    logic wr_acc;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign wr_acc = acc && pwrite;
    assign issue = acc && pwrite && paddr == FCP_CMD_OFF && pwdata[FCP_CMD_GO_BIT];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_issue;
        issue;
    endsequence
    ready_no_wait_a: assert property (acc |-> pready)
        else $error("pready low in access");
    unmapped_error_a: assert property (acc && (paddr > FCP_REL_OFF || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("no error on unmapped access");
    mapped_clean_a: assert property (acc && paddr <= FCP_REL_OFF && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped access");
    valid_cause_a: assert property (result_valid |-> $past(issue, 2))
        else $error("result strobe without issue");
    valid_pulse_a: assert property (s_issue ##2 result_valid |=> !result_valid)
        else $error("result strobe too long");
    rel_consistent_a: assert property (rd && paddr == FCP_REL_OFF |->
        !(prdata[2] && (prdata[0] || prdata[1])) && !(prdata[0] && prdata[1]))
        else $error("inconsistent relations");
    res_low_mask_a: assert property (rd && paddr == FCP_RES_LO_OFF |-> prdata == 32'h0 || prdata == 32'hffff_ffff)
        else $error("low result not a mask");
    res_high_mask_a: assert property (rd && paddr == FCP_RES_HI_OFF |-> prdata == 32'h0 || prdata == 32'hffff_ffff)
        else $error("high result not a mask");
    status_width_a: assert property (rd && paddr == FCP_STATUS_OFF |-> prdata[31:5] == 27'h0)
        else $error("extra exception bits");
    irq_clear_a: assert property ($fell(irq) |-> $past(wr_acc, 1) || $past(wr_acc, 2))
        else $error("interrupt fell without a write");
endmodule // fcp_compare_checker

// [verification/fcp_apb_master.sv]
/* APB host model standing in for the decoder side.
 * Assumes a zero or more wait state slave on mclk. */
`timescale 1ns/1ps
module fcp_apb_master (
    // Clock
    input wire logic mclk,
    // Request
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] d, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        // Write data is not held when reading, so a stale value cannot pass
        pwdata <= w ? wd : ~pwdata;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
    endtask
endmodule // fcp_apb_master

// [verification/fp_compare_predicate_tb_top.sv]
/* Self-checking bench: reset, interrupt, unmapped, corner and random compares.
 * Assumes fcp_apb_master as bus host and the checker bound at the foot. */
`timescale 1ns/1ps
module fp_compare_predicate_tb_top;
    import fcp_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, result_valid, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [63:0] res_exp = 64'h0;
    logic [3:0] rel_exp = 4'h0;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;

    fcp_compare_unit uut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .result_valid(result_valid));
    fcp_apb_master host (.mclk(mclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            final_report;
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdat, rerr);
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, rdat, rerr);
    endtask

    // Class of an operand: {nan, quiet}; single sits in the top word here
    function automatic logic [1:0] cls(input logic [63:0] x, input logic d);
        cls[1] = d ? (&x[62:52] && |x[51:0]) : (&x[62:55] && |x[54:32]);
        cls[0] = d ? x[51] : x[54];
    endfunction
    function automatic logic [63:0] key(input logic [63:0] x);
        return x[63] ? ~x : {1'b1, x[62:0]};
    endfunction
    // Returns {less, equal, unordered, reserved, invalid, updates, predicate}
    function automatic logic [6:0] model(input logic [63:0] a, input logic [63:0] b,
                                          input logic [1:0] f, input logic [4:0] c);
        logic [63:0] x, y;
        logic [1:0] ca, cb;
        logic un, eq, lt, rsv, inv;
        x = f[0] ? a : {a[31:0], 32'h0};
        y = f[0] ? b : {b[31:0], 32'h0};
        ca = cls(x, f[0]);
        cb = cls(y, f[0]);
        un = ca[1] | cb[1];
        eq = !un && (x == y || (x[62:0] == 63'h0 && y[62:0] == 63'h0));
        lt = !un && !eq && key(x) < key(y);
        rsv = f[1] || (c[4] && !(c[3:0] inside {4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb}));
        inv = !rsv && ((ca == 2'b10) || (cb == 2'b10) || (c[3] && ((ca == 2'b11) || (cb == 2'b11))));
        return {lt, eq, un, rsv, inv, !rsv && !inv, c[4] ^ ((c[2] & lt) | (c[1] & eq) | (c[0] & un))};
    endfunction
    function automatic logic [63:0] pick(input int k, input logic [63:0] o, input logic d);
        logic [63:0] r;
        r = {$urandom, $urandom};
        case (k)
            1: return o;
            2: return d ? {r[63], 11'h7ff, 1'b1, r[50:0]} : {r[63:32], r[31], 8'hff, 1'b1, r[21:0]};
            3: return d ? {r[63], 11'h7ff, 1'b0, r[50:1], 1'b1} : {r[63:32], r[31], 8'hff, 1'b0, r[21:1], 1'b1};
            4: return d ? {r[63], 63'h0} : {r[63:32], r[31], 31'h0};
            default: return r;
        endcase
    endfunction

    task automatic run_cmp(input logic [4:0] c, input logic [1:0] f, input logic [63:0] a, input logic [63:0] b);
        logic [6:0] e;
        e = model(a, b, f, c);
        wr(FCP_CTRL_OFF, {16'h0001, 6'h0, f, 3'h0, c});
        wr(FCP_OPA_LO_OFF, a[31:0]);
        wr(FCP_OPA_HI_OFF, a[63:32]);
        wr(FCP_OPB_LO_OFF, b[31:0]);
        wr(FCP_OPB_HI_OFF, b[63:32]);
        wr(FCP_STATUS_OFF, 32'h1f);
        wr(FCP_CMD_OFF, 32'h1);
        if (e[1]) begin
            res_exp = f[0] ? {64{e[0]}} : {32'h0, {32{e[0]}}};
            rel_exp = {e[0], e[4], e[5], e[6]};
        end
        rd(FCP_STATUS_OFF);
        chk_word(rdat, {27'h0, e[3], 2'h0, e[2], 1'b1});
        chk_bit(irq, 1'b1);
        rd(FCP_RES_LO_OFF);
        chk_word(rdat, res_exp[31:0]);
        rd(FCP_RES_HI_OFF);
        chk_word(rdat, res_exp[63:32]);
        rd(FCP_REL_OFF);
        chk_word(rdat, {28'h0, rel_exp});
    endtask

    initial begin
        logic [63:0] a;
        logic [1:0] f;
        rst_n = 1'b0;
        void'($urandom(73));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(FCP_STATUS_OFF);
        chk_word(rdat, 32'h0);
        rd(FCP_CTRL_OFF);
        chk_word(rdat, 32'h0);
        $display("test reset done");
        wr(FCP_MASK_OFF, 32'h0);
        wr(FCP_CMD_OFF, 32'h1);
        rd(FCP_STATUS_OFF);
        chk_word(rdat, 32'h9);
        chk_bit(irq, 1'b0);
        wr(FCP_MASK_OFF, 32'h1f);
        repeat (3) @(posedge mclk);
        chk_bit(irq, 1'b1);
        wr(FCP_STATUS_OFF, 32'h1f);
        repeat (3) @(posedge mclk);
        chk_bit(irq, 1'b0);
        $display("test interrupt done");
        rd(8'h2c);
        chk_bit(rerr, 1'b1);
        chk_word(rdat, 32'h0);
        wr(8'h09, 32'hffff_ffff);
        chk_bit(rerr, 1'b1);
        $display("test unmapped done");
        run_cmp(5'h07, FCP_FMT_DOUBLE, 64'h0, 64'h8000_0000_0000_0000);
        run_cmp(5'h0c, FCP_FMT_SINGLE, 64'h3f80_0000, 64'h4000_0000);
        run_cmp(5'h04, FCP_FMT_SINGLE, 64'h4000_0000, 64'h3f80_0000);
        $display("test corners done");
        for (int c = 0; c < 32; c++) begin
            repeat (4) begin
                f = ($urandom_range(15) == 0) ? 2'h2 : 2'($urandom_range(1));
                a = pick($urandom_range(4), 64'h0, f[0]);
                run_cmp(5'(c), f, a, pick($urandom_range(4), a, f[0]));
            end
        end
        $display("test random done");
        final_report;
    end
endmodule // fp_compare_predicate_tb_top

bind fcp_compare_unit fcp_compare_checker u_chk (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .result_valid(result_valid));
